// ===== rtl/dbg_state_defs.svh
`ifndef DBG_STATE_DEFS_SVH
`define DBG_STATE_DEFS_SVH

// ----------------------------------------
// system register encodings {op0,op1,crn,crm,op2}
// ----------------------------------------
`define SAVED_STATUS_ENC 16'hDA28
`define HYP_DBG_CFG_ENC 16'hE089

// ----------------------------------------
// saved status fields
// ----------------------------------------
`define SS_NZCV_HI 31
`define SS_NZCV_LO 28
`define SS_PAN_BIT 22
`define SS_STEP_BIT 21
`define SS_ILL_BIT 20
`define SS_GE_HI 19
`define SS_GE_LO 16
`define SS_IT_HI 15
`define SS_IT_LO 10
`define SS_E_BIT 9
`define SS_T_BIT 5
`define SS_M4_BIT 4
`define SS_ABT_BIT 8
`define SS_IRQ_BIT 7
`define SS_FIQ_BIT 6
`define SS_RES0_64 32'h0F8FFC20
`define SS_RES0_32 32'hFF800000

// ----------------------------------------
// hyp debug config fields
// ----------------------------------------
`define HDC_GCD_BIT 17
`define HDC_ROM_BIT 11
`define HDC_TDA_BIT 9
`define HDC_WMASK 32'h00020FFF
`define HDC_RESET 32'h00000000

`endif

// ===== rtl/dbg_state_pkg.sv
package dbg_state_pkg;
	typedef enum logic [1:0] {
		EL0 = 2'b00,
		EL1 = 2'b01,
		EL2 = 2'b10,
		EL3 = 2'b11
	} el_e;

	typedef enum logic [2:0] {
		TRAP_NONE = 3'b000,
		TRAP_DEBUG = 3'b001,
		TRAP_EL2 = 3'b010,
		TRAP_EL3 = 3'b011,
		TRAP_UNDEF = 3'b100
	} trap_e;
endpackage

// ===== rtl/dbg_trap_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbg_state_defs.svh"

// ----------------------------------------
// trap priority for one debug register access
// ----------------------------------------
module dbg_trap_check (
	input wire logic [1:0] cur_el,
	input wire logic nonsecure,
	input wire logic el2_impl,
	input wire logic el3_impl,
	input wire logic external_debug_trap_ctl,
	input wire logic os_lock_flag,
	input wire logic hyp_debug_access_trap,
	input wire logic monitor_debug_access_trap,
	output dbg_state_pkg::trap_e trap
);
	always_comb begin
		trap = dbg_state_pkg::TRAP_NONE;
		// debug halt trap has the highest priority
		if (external_debug_trap_ctl && !os_lock_flag && cur_el != 2'h0) begin
			trap = dbg_state_pkg::TRAP_DEBUG;
		end else if (el2_impl && nonsecure && hyp_debug_access_trap && cur_el == 2'h1) begin
			trap = dbg_state_pkg::TRAP_EL2;
		end else if (el3_impl && monitor_debug_access_trap &&
			(cur_el == 2'h1 || cur_el == 2'h2)) begin
			trap = dbg_state_pkg::TRAP_EL3;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/dbg_state_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbg_state_defs.svh"

// Functional notes
// - halt trap when external trap set, unlocked
// - hyp access trap for nonsecure EL1
// - monitor access trap for EL1, EL2
// - bit 22 saves and restores PRIV_ACCESS_NEVER
// - bits 21, 20 save step, illegal
// - bits 19:16 hold GE flags
// - bits 15:10 hold upper cond block
// - bit 9 is data byte order
// - byte order bit fixed per support
// - bits 8:6 hold abort, irq, fiq masks
// - bit 5 instruction set, 64-bit res0
// - bit 4 records entry execution state
// - 32-bit mode codes, listed nine valid
// - 64-bit flags 31:28, reserved zero bits
// - bit 9 masks same-level debug exceptions
// - 64-bit mode codes, el and sp
// - reserved 64-bit mode gives illegal return
// - saved status accessible only in debug
// - no EL2: config reads zero from EL3
// - config resets only into 64-bit state
// - bit 17 disables EL2 counting, resets 0
// - bit 11 traps nonsecure rom accesses

module dbg_state_regs #(
	parameter bit EL2_IMPL = 1'b1,
	parameter bit EL3_IMPL = 1'b1,
	parameter bit BIG_END_OK = 1'b1,
	parameter bit LITTLE_END_OK = 1'b1,
	parameter bit BIG_EL0_ONLY = 1'b0,
	parameter bit LITTLE_EL0_ONLY = 1'b0,
	parameter bit PAN_IMPL = 1'b1,
	parameter logic [4:0] COUNTER_NUM = 5'h06
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic reset_to_64,
	// core state at entry
	input wire logic dbg_entry,
	input wire logic dbg_exit,
	input wire logic [31:0] core_pstate,
	// system register access
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire logic [15:0] acc_enc,
	input wire logic [31:0] acc_wdata,
	// trap controls
	input wire logic [1:0] cur_el,
	input wire logic nonsecure,
	input wire logic external_debug_trap_ctl,
	input wire logic os_lock_flag,
	input wire logic monitor_debug_access_trap,
	input wire logic rom_access,
	// counter controls
	input wire logic secure_noninv_ok,
	input wire logic cycle_disable_prohibited,
	input wire logic [4:0] ctr_index,
	input wire logic ctr_is_cycle,
	// answers to the core
	output logic [31:0] acc_rdata,
	output logic acc_done,
	output dbg_state_pkg::trap_e acc_trap,
	output logic in_debug,
	output logic [31:0] restore_pstate,
	output logic restore_valid,
	output logic illegal_return,
	output logic debug_mask,
	output logic rom_addr_trap,
	output logic ctr_prohibit
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic in_debug;
		logic [31:0] saved;
		logic [31:0] hcfg;
		logic [31:0] rdata;
		logic done;
		dbg_state_pkg::trap_e trap;
		logic [31:0] restore;
		logic restore_valid;
		logic illegal;
	} state_s;

	state_s st_q;
	state_s st_d;
	dbg_state_pkg::trap_e trap_w;
	logic hit_saved;
	logic hit_hcfg;

	dbg_trap_check u_trap (
		.cur_el(cur_el),
		.nonsecure(nonsecure),
		.el2_impl(EL2_IMPL),
		.el3_impl(EL3_IMPL),
		.external_debug_trap_ctl(external_debug_trap_ctl),
		.os_lock_flag(os_lock_flag),
		.hyp_debug_access_trap(st_q.hcfg[`HDC_TDA_BIT]),
		.monitor_debug_access_trap(monitor_debug_access_trap),
		.trap(trap_w)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// force the byte order bit where one order is missing
	function automatic logic fix_endian(input logic e, input logic to_el0);
		logic r;
		logic big_gone;
		logic little_gone;
		r = e;
		// support at the lowest level only does not count for a return elsewhere
		big_gone = !BIG_END_OK || (BIG_EL0_ONLY && !to_el0);
		little_gone = !LITTLE_END_OK || (LITTLE_EL0_ONLY && !to_el0);
		if (big_gone) begin
			r = 1'b0;
		end else if (little_gone) begin
			r = 1'b1;
		end
		return r;
	endfunction

	// clean a value by layout, chosen by bit 4
	// fields are copied one by one so reserved bits can never leak through
	function automatic logic [31:0] shape(input logic [31:0] v);
		logic [31:0] r;
		r = 32'h00000000;
		// fields shared by both layouts
		r[`SS_STEP_BIT] = v[`SS_STEP_BIT];
		r[`SS_ILL_BIT] = v[`SS_ILL_BIT];
		r[`SS_ABT_BIT] = v[`SS_ABT_BIT];
		r[`SS_IRQ_BIT] = v[`SS_IRQ_BIT];
		r[`SS_FIQ_BIT] = v[`SS_FIQ_BIT];
		r[`SS_M4_BIT] = v[`SS_M4_BIT];
		r[`SS_PAN_BIT] = PAN_IMPL ? v[`SS_PAN_BIT] : 1'b0;
		if (v[`SS_M4_BIT]) begin
			// narrow layout
			r[`SS_GE_HI:`SS_GE_LO] = v[`SS_GE_HI:`SS_GE_LO];
			r[`SS_IT_HI:`SS_IT_LO] = v[`SS_IT_HI:`SS_IT_LO];
			r[`SS_E_BIT] = fix_endian(v[`SS_E_BIT], v[3:0] == 4'h0);
			r[`SS_T_BIT] = v[`SS_T_BIT];
			r[3:0] = v[3:0];
		end else begin
			// wide layout: 27:23, 19:10 and 5 stay zero
			r[`SS_NZCV_HI:`SS_NZCV_LO] = v[`SS_NZCV_HI:`SS_NZCV_LO];
			r[`SS_E_BIT] = v[`SS_E_BIT];
			r[3:0] = v[3:0];
		end
		return r;
	endfunction

	// 64-bit mode field legality
	function automatic logic mode64_ok(input logic [3:0] m);
		logic ok;
		ok = 1'b0;
		case (m)
			4'h0, 4'h4, 4'h5, 4'h8, 4'h9, 4'hC, 4'hD: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		if (m[3:2] == 2'h2 && !EL2_IMPL) begin
			ok = 1'b0;
		end
		if (m[3:2] == 2'h3 && !EL3_IMPL) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	// narrow layout mode field legality, nine listed codes
	function automatic logic mode32_ok(input logic [3:0] m);
		logic ok;
		ok = 1'b0;
		case (m)
			4'h0, 4'h1, 4'h2, 4'h3: ok = 1'b1;
			4'h6, 4'h7: ok = 1'b1;
			4'hA, 4'hB, 4'hF: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		// the hyp and monitor modes need their levels
		if (m == 4'hA && !EL2_IMPL) begin
			ok = 1'b0;
		end
		if (m == 4'h6 && !EL3_IMPL) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	assign hit_saved = acc_enc == `SAVED_STATUS_ENC;
	assign hit_hcfg = acc_enc == `HYP_DBG_CFG_ENC;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		st_d.restore_valid = 1'b0;
		st_d.illegal = 1'b0;
		st_d.trap = dbg_state_pkg::TRAP_NONE;

		// ----------------------------------------
		// debug state entry and exit
		// ----------------------------------------
		if (dbg_entry && !st_q.in_debug) begin
			// entry captures state, flags, masks and mode
			st_d.in_debug = 1'b1;
			st_d.saved = shape(core_pstate);
		end else if (dbg_exit && st_q.in_debug) begin
			st_d.in_debug = 1'b0;
			st_d.restore = shape(st_q.saved);
			st_d.restore_valid = 1'b1;
			if (!st_q.saved[`SS_M4_BIT] && !mode64_ok(st_q.saved[3:0])) begin
				st_d.illegal = 1'b1;
			end
		end


		// ----------------------------------------
		// register access
		// ----------------------------------------
		if (acc_valid) begin
			st_d.done = 1'b1;
			st_d.rdata = 32'h00000000;
			if (hit_saved) begin
				if (!st_q.in_debug) begin
					st_d.trap = dbg_state_pkg::TRAP_UNDEF;
				end else if (acc_write) begin
					st_d.saved = shape(acc_wdata);
					// reserved narrow modes are unpredictable: keep the old mode
					if (acc_wdata[`SS_M4_BIT] && !mode32_ok(acc_wdata[3:0])) begin
						st_d.saved[3:0] = st_q.saved[3:0];
					end
				end else begin
					st_d.rdata = st_q.saved;
				end
			end else if (hit_hcfg) begin
				// the config register is for the hypervisor and the monitor only
				if (cur_el == 2'h0 || cur_el == 2'h1) begin
					st_d.trap = dbg_state_pkg::TRAP_UNDEF;
				end else if (cur_el == 2'h2 && EL3_IMPL && monitor_debug_access_trap) begin
					st_d.trap = dbg_state_pkg::TRAP_EL3;
				end else if (!EL2_IMPL) begin
					st_d.rdata = 32'h00000000;
				end else if (acc_write) begin
					st_d.hcfg = acc_wdata & `HDC_WMASK;
				end else begin
					st_d.rdata = st_q.hcfg & `HDC_WMASK;
				end
			end else begin
				// every other debug encoding goes through the trap priority
				st_d.trap = trap_w;
			end
		end


		// ----------------------------------------
		// reset
		// ----------------------------------------
		// saved status keeps its contents: it only means something in debug
		if (sys_rst) begin
			st_d.in_debug = 1'b0;
			st_d.done = 1'b0;
			st_d.rdata = 32'h00000000;
			st_d.restore = 32'h00000000;
			// unknown outside 64-bit reset: keep old contents
			if (reset_to_64) begin
				st_d.hcfg = `HDC_RESET | {27'h0000000, COUNTER_NUM};
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// reset must act even while the enable is low
	always_ff @(posedge clk_sys) begin
		if (sys_rst || clk_en) begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign acc_rdata = st_q.rdata;
	assign acc_done = st_q.done;
	assign acc_trap = st_q.trap;
	assign in_debug = st_q.in_debug;
	assign restore_pstate = st_q.restore;
	assign restore_valid = st_q.restore_valid;
	assign illegal_return = st_q.illegal;

	// ----------------------------------------
	// derived controls
	// ----------------------------------------
	logic saved_wide;
	logic low_nonsecure;
	logic at_el2;
	logic hcfg_rom_trap;
	logic hcfg_count_off;
	logic [4:0] hcfg_partition;
	logic ctr_covered;

	always_comb begin
		saved_wide = !st_q.saved[`SS_M4_BIT];
		low_nonsecure = nonsecure && !cur_el[1];
		at_el2 = cur_el == 2'h2;
		hcfg_rom_trap = st_q.hcfg[`HDC_ROM_BIT];
		hcfg_count_off = st_q.hcfg[`HDC_GCD_BIT];
		hcfg_partition = st_q.hcfg[4:0];
		// event counters at or above the partition are never held off here; the cycle counter follows cycle_disable_prohibited
		if (ctr_is_cycle) begin
			ctr_covered = cycle_disable_prohibited;
		end else begin
			ctr_covered = ctr_index < hcfg_partition;
		end
	end

	// only same-level targets are masked by bit 9; higher targets are the core's call
	assign debug_mask = saved_wide && st_q.saved[`SS_E_BIT];
	assign rom_addr_trap = rom_access && low_nonsecure && hcfg_rom_trap;
	assign ctr_prohibit = at_el2 && hcfg_count_off && !secure_noninv_ok &&
		ctr_covered;
endmodule
`default_nettype wire

// ===== testbench/dbg_state_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbg_state_defs.svh"
module dbg_state_chk (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic dbg_entry,
	input wire logic dbg_exit,
	input wire logic acc_valid,
	input wire logic [15:0] acc_enc,
	input wire logic [1:0] cur_el,
	input wire logic external_debug_trap_ctl,
	input wire logic os_lock_flag,
	input wire logic monitor_debug_access_trap,
	input wire logic acc_done,
	input wire dbg_state_pkg::trap_e acc_trap,
	input wire logic in_debug,
	input wire logic restore_valid
);
// ----------
// access and state checks
// ----------
default clocking @(posedge clk_sys); endclocking
default disable iff (sys_rst);
wire tk = acc_valid && clk_en;
wire sv = tk && acc_enc == `SAVED_STATUS_ENC;
wire oth = tk && acc_enc != `SAVED_STATUS_ENC && acc_enc != `HYP_DBG_CFG_ENC;
property p_done; tk |=> acc_done; endproperty
a_done: assert property (p_done)
	else $error("missing done");
property p_quiet; clk_en && !acc_valid |=> !acc_done; endproperty
a_quiet: assert property (p_quiet)
	else $error("done without request");
property p_sv_out; sv && !in_debug |=> acc_trap == 3'h4; endproperty
a_sv_out: assert property (p_sv_out)
	else $error("saved status open outside debug");
property p_sv_in; sv && in_debug |=> acc_trap == 3'h0; endproperty
a_sv_in: assert property (p_sv_in)
	else $error("saved status refused in debug");
property p_halt; oth && external_debug_trap_ctl && !os_lock_flag && cur_el != 2'h0
	|=> acc_trap == 3'h1; endproperty
a_halt: assert property (p_halt)
	else $error("halt trap missing");
property p_mon; oth && !external_debug_trap_ctl && monitor_debug_access_trap && cur_el == 2'h2
	|=> acc_trap == 3'h3; endproperty
a_mon: assert property (p_mon)
	else $error("monitor trap missing");
property p_enter; dbg_entry && clk_en && !dbg_exit |=> in_debug; endproperty
a_enter: assert property (p_enter)
	else $error("debug not entered");
property p_exit; dbg_exit && clk_en && in_debug && !dbg_entry |=> restore_valid ##1 !restore_valid;
endproperty
a_exit: assert property (p_exit)
	else $error("restore pulse wrong");
endmodule
bind dbg_state_regs dbg_state_chk chk_u (.clk_sys, .sys_rst, .clk_en, .dbg_entry, .dbg_exit,
	.acc_valid, .acc_enc, .cur_el, .external_debug_trap_ctl, .os_lock_flag,
	.monitor_debug_access_trap, .acc_done, .acc_trap, .in_debug, .restore_valid);
`default_nettype wire

// ===== testbench/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic clk_sys,
	output logic acc_valid,
	output logic acc_write,
	output logic [15:0] acc_enc,
	output logic [31:0] acc_wdata
);
// ----------
// register moves, one per call
// ----------
initial begin
	acc_valid = 1'b0;
	acc_write = 1'b0;
	acc_enc = 16'h0000;
	acc_wdata = 32'h00000000;
end
task automatic access(input logic w, input logic [15:0] e, input logic [31:0] d);
	@(posedge clk_sys);
	#1;
	acc_valid = 1'b1;
	acc_write = w;
	acc_enc = e;
	acc_wdata = d;
	@(posedge clk_sys);
	#1;
	acc_valid = 1'b0;
	// released lines flip so stale values never look valid
	acc_enc = ~e;
	acc_wdata = ~d;
endtask
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbg_state_defs.svh"
module tb;
logic clk_sys = 1'b0;
logic sys_rst = 1'b1;
logic ent = 1'b0;
logic ext = 1'b0;
logic [31:0] pst = 32'h00000000;
logic [1:0] el = 2'h2;
logic ns = 1'b1;
logic xt = 1'b0;
logic lk = 1'b0;
logic mon = 1'b0;
logic rom = 1'b0;
logic sok = 1'b0;
logic av, aw, done, rv, ill, dm, rt, cp, ind;
logic [15:0] ae;
logic [31:0] wd, rd, rp;
dbg_state_pkg::trap_e trap;
int err_count = 0;
int num_checks = 0;
always #20 clk_sys = ~clk_sys;
core_model core_u (.clk_sys, .acc_valid(av), .acc_write(aw), .acc_enc(ae), .acc_wdata(wd));
dbg_state_regs dut_u (.clk_sys, .sys_rst, .clk_en(1'b1), .reset_to_64(1'b1), .dbg_entry(ent),
	.dbg_exit(ext), .core_pstate(pst), .acc_valid(av), .acc_write(aw), .acc_enc(ae),
	.acc_wdata(wd), .cur_el(el), .nonsecure(ns), .external_debug_trap_ctl(xt),
	.os_lock_flag(lk), .monitor_debug_access_trap(mon), .rom_access(rom),
	.secure_noninv_ok(sok), .cycle_disable_prohibited(1'b0), .ctr_index(5'h00),
	.ctr_is_cycle(1'b0), .acc_rdata(rd), .acc_done(done), .acc_trap(trap), .in_debug(ind),
	.restore_pstate(rp), .restore_valid(rv), .illegal_return(ill), .debug_mask(dm),
	.rom_addr_trap(rt), .ctr_prohibit(cp));
// ----------
// helpers
// ----------
task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
	num_checks++;
	if (g !== e) begin
		err_count++;
		$display("ERROR %s expected %h seen %h", n, e, g);
	end
endtask
task automatic complete_run;
	if (err_count == 0 && num_checks > 0) begin
		$display("Result: passed");
	end else begin
		$display("Result: failed");
	end
	$finish;
endtask
task automatic acc(input logic [1:0] l, input logic w, input logic [15:0] e, input logic [31:0] d);
	el = l;
	core_u.access(w, e, d);
endtask
task automatic dbg(input logic en, input logic [31:0] p);
	@(posedge clk_sys);
	#1;
	ent = en;
	ext = !en;
	pst = p;
	@(posedge clk_sys);
	#1;
	ent = 1'b0;
	ext = 1'b0;
	pst = ~p;
endtask
task automatic tr(input logic [1:0] l, input logic [3:0] f, input logic [2:0] t);
	{ns, xt, lk, mon} = f;
	acc(l, 1'b0, 16'h8005, 32'h0);
	chk("trap", {29'h0, t}, trap);
endtask
// ----------
// scenarios
// ----------
task automatic t_cfg;
	acc(2'h2, 1'b0, `HYP_DBG_CFG_ENC, 32'h0);
	chk("cfg reset", 32'h00000006, rd);
	acc(2'h2, 1'b1, `HYP_DBG_CFG_ENC, 32'hFFFFFFFF);
	acc(2'h2, 1'b0, `HYP_DBG_CFG_ENC, 32'h0);
	chk("cfg mask", 32'h00020FFF, rd);
	#1;
	chk("count hold", 32'h1, cp);
	sok = 1'b1;
	#1;
	chk("count auth", 32'h0, cp);
	el = 2'h1;
	rom = 1'b1;
	#1;
	chk("rom trap", 32'h1, rt);
	ns = 1'b0;
	#1;
	chk("rom secure", 32'h0, rt);
endtask
task automatic t_trap;
	tr(2'h1, 4'h9, 3'h2);
	tr(2'h1, 4'hC, 3'h1);
	tr(2'h3, 4'h4, 3'h1);
	tr(2'h1, 4'hE, 3'h2);
	tr(2'h2, 4'h9, 3'h3);
	tr(2'h1, 4'h1, 3'h3);
	tr(2'h1, 4'h0, 3'h0);
endtask
task automatic t_sav;
	acc(2'h1, 1'b0, `SAVED_STATUS_ENC, 32'h0);
	chk("saved outside", 32'h4, trap);
	dbg(1'b1, 32'h0045A3F3);
	chk("in debug", 32'h1, ind);
	acc(2'h0, 1'b0, `SAVED_STATUS_ENC, 32'h0);
	chk("saved 32", 32'h0045A3F3, rd);
	dbg(1'b0, 32'h0);
	chk("restore 32", 32'h0045A3F3, rp);
	chk("restore valid", 32'h1, rv);
	dbg(1'b1, 32'h0);
	acc(2'h0, 1'b1, `SAVED_STATUS_ENC, 32'hFFFFFFE5);
	acc(2'h0, 1'b0, `SAVED_STATUS_ENC, 32'h0);
	// reserved fields of the wide layout drop out, flags and step survive
	chk("saved 64", 32'hF07003C5, rd);
	chk("dbg mask", 32'h1, dm);
	dbg(1'b0, 32'h0);
	chk("restore 64", 32'hF07003C5, rp);
	chk("legal ret", 32'h0, ill);
	dbg(1'b1, 32'h00000006);
	dbg(1'b0, 32'h0);
	chk("bad mode ret", 32'h1, ill);
endtask
initial begin
	repeat (3) @(posedge clk_sys);
	#1;
	sys_rst = 1'b0;
	t_cfg;
	t_trap;
	t_sav;
	complete_run;
end
initial begin
	#100000;
	err_count++;
	complete_run;
end
endmodule
`default_nettype wire
